// file: verilog/checksum_unit.sv
`include "checksum_defs.svh"
`default_nettype none

module checksum_unit (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	sfr_link_if.device_mp    link,
	output logic             flash_rd_o,
	output logic [17:0]      flash_addr_o,
	input  wire logic [7:0]  flash_data_i,
	input  wire logic        flash_valid_i,
	output logic [31:0]      crc_result_o,
	output logic             scan_busy_o
);

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	function automatic logic [31:0] fold_byte(input logic [31:0] c, input logic [7:0] b,
		input logic w16);
		logic [31:0] r;
		r = c;
		if (w16) begin
			r[15:8] = r[15:8] ^ b;
			for (int i = 0; i < 8; i++) begin
				if (r[15]) begin
					r[15:0] = {r[14:0], 1'b0} ^ `CK_POLY16;
				end else begin
					r[15:0] = {r[14:0], 1'b0};
				end
			end
		end else begin
			r[7:0] = r[7:0] ^ b;
			for (int i = 0; i < 8; i++) begin
				if (r[0]) begin
					r = (r >> 1) ^ `CK_POLY32_REFL;
				end else begin
					r = r >> 1;
				end
			end
		end
		return r;
	endfunction

	// Byte lane reached through the result port
	function automatic logic [1:0] lane_of(input logic [1:0] pnt, input logic w16);
		return w16 ? {1'b0, pnt[0]} : pnt;
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [31:0]               crc_r, crc_nxt;
	logic                      width16_r;
	logic                      initval_r;
	logic [1:0]                pnt_r, pnt_nxt;
	logic [7:0]                input_r;
	logic                      auto_en_r;
	logic [5:0]                start_sec_r;
	logic [5:0]                sec_count_r;
	logic [7:0]                rdata_r;
	checksum_pkg::scan_state_e state_r, state_nxt;
	logic [15:0]               scan_addr_r, scan_addr_nxt;
	logic [16:0]               remain_r, remain_nxt;
	logic [7:0]                read_mux;

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	wire        busy       = (state_r != checksum_pkg::S_IDLE);
	wire        wr_ctrl    = link.sfr_wr && (link.sfr_addr == `CK_ADDR_CONTROL);
	wire        wr_input   = link.sfr_wr && (link.sfr_addr == `CK_ADDR_INPUT);
	wire        wr_result  = link.sfr_wr && (link.sfr_addr == `CK_ADDR_RESULT);
	wire        rd_result  = link.sfr_rd && (link.sfr_addr == `CK_ADDR_RESULT);
	wire        wr_auto    = link.sfr_wr && (link.sfr_addr == `CK_ADDR_AUTO);
	wire        wr_count   = link.sfr_wr && (link.sfr_addr == `CK_ADDR_COUNT);
	wire        do_init    = wr_ctrl && link.sfr_wdata[`CK_CTRL_INIT_BIT];
	wire        new_w16    = link.sfr_wdata[`CK_CTRL_WIDTH_BIT];
	wire        new_val    = link.sfr_wdata[`CK_CTRL_VAL_BIT];
	// A write that merely rewrites the same value still triggers a scan
	wire        scan_start = wr_ctrl && auto_en_r && !busy;
	wire        full_space = (start_sec_r == 6'h00) && (sec_count_r == 6'h00);
	wire [16:0] scan_len   = full_space ? `CK_FULL_SPACE
		: {1'b0, sec_count_r, 10'h000};
	wire [1:0]  acc_lane   = lane_of(pnt_r, width16_r);
	wire [7:0]  result_byte = crc_r[8*acc_lane +: 8];
	wire        scan_byte  = (state_r == checksum_pkg::S_WAIT) && flash_valid_i;

	// ------------------------------------------------------------------------
	// Result register and pointer
	// ------------------------------------------------------------------------
	always_comb begin
		crc_nxt = crc_r;
		pnt_nxt = pnt_r;
		if (wr_ctrl) begin
			pnt_nxt = link.sfr_wdata[1:0];
		end
		if (wr_result || rd_result) begin
			pnt_nxt = pnt_r + 2'd1;
		end
		if (do_init) begin
			crc_nxt = new_val ? `CK_INIT_ONES : `CK_INIT_ZERO;
		end else if (wr_result) begin
			crc_nxt[8*acc_lane +: 8] = link.sfr_wdata;
		end else if (wr_input) begin
			crc_nxt = fold_byte(crc_r, link.sfr_wdata, width16_r);
		end else if (scan_byte) begin
			crc_nxt = fold_byte(crc_r, flash_data_i, width16_r);
		end
	end

	// ------------------------------------------------------------------------
	// Flash scan sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		state_nxt     = state_r;
		scan_addr_nxt = scan_addr_r;
		remain_nxt    = remain_r;
		unique case (state_r)
			checksum_pkg::S_IDLE: begin
				if (scan_start && (scan_len != 17'h0_0000)) begin
					scan_addr_nxt = {start_sec_r, 10'h000};
					remain_nxt    = scan_len;
					state_nxt     = checksum_pkg::S_FETCH;
				end
			end
			checksum_pkg::S_FETCH: begin
				state_nxt = checksum_pkg::S_WAIT;
			end
			checksum_pkg::S_WAIT: begin
				if (flash_valid_i) begin
					scan_addr_nxt = scan_addr_r + 16'h0001;
					remain_nxt    = remain_r - 17'h0_0001;
					state_nxt     = (remain_r == 17'h0_0001) ? checksum_pkg::S_IDLE
						: checksum_pkg::S_FETCH;
				end
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			crc_r       <= 32'h0000_0000;
			pnt_r       <= 2'b00;
			width16_r   <= 1'b0;
			initval_r   <= 1'b0;
			input_r     <= 8'h00;
			auto_en_r   <= 1'b0;
			start_sec_r <= 6'h00;
			sec_count_r <= 6'h00;
			rdata_r     <= 8'h00;
			state_r     <= checksum_pkg::S_IDLE;
			scan_addr_r <= 16'h0000;
			remain_r    <= 17'h0_0000;
		end else begin
			crc_r       <= crc_nxt;
			pnt_r       <= pnt_nxt;
			state_r     <= state_nxt;
			scan_addr_r <= scan_addr_nxt;
			remain_r    <= remain_nxt;
			if (wr_ctrl) begin
				width16_r <= new_w16;
				initval_r <= new_val;
			end
			if (wr_input) begin
				input_r <= link.sfr_wdata;
			end
			if (wr_auto) begin
				auto_en_r   <= link.sfr_wdata[`CK_AUTO_EN_BIT];
				start_sec_r <= link.sfr_wdata[5:0];
			end
			if (wr_count) begin
				sec_count_r <= link.sfr_wdata[5:0];
			end
			if (link.sfr_rd) begin
				rdata_r <= read_mux;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Read data and outputs
	// ------------------------------------------------------------------------
	always_comb begin
		unique case (link.sfr_addr)
			`CK_ADDR_RESULT:  read_mux = result_byte;
			`CK_ADDR_CONTROL: read_mux = {3'b000, width16_r, 1'b0,
				initval_r, pnt_r};
			`CK_ADDR_INPUT:   read_mux = input_r;
			`CK_ADDR_AUTO:    read_mux = {auto_en_r, !busy, start_sec_r};
			`CK_ADDR_COUNT:   read_mux = {2'b00, sec_count_r};
			default:          read_mux = 8'h00;
		endcase
	end

	// Hold rises in the trigger cycle itself so no instruction slips past
	assign link.cpu_hold  = busy || scan_start;
	assign link.sfr_rdata = rdata_r;
	assign flash_rd_o     = (state_r == checksum_pkg::S_FETCH);
	// Bank select forms the upper address; the CPU sets it before the scan
	assign flash_addr_o   = {link.code_bank_select, scan_addr_r};
	assign crc_result_o   = crc_r;
	assign scan_busy_o    = busy;

endmodule // checksum_unit

`default_nettype wire

// file: verilog/checksum_defs.svh
`ifndef CHECKSUM_DEFS_SVH
`define CHECKSUM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define CK_ADDR_RESULT      8'h91
`define CK_ADDR_CONTROL     8'h92
`define CK_ADDR_INPUT       8'h93
`define CK_ADDR_AUTO        8'h96
`define CK_ADDR_COUNT       8'h97

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CK_CTRL_WIDTH_BIT   4
`define CK_CTRL_INIT_BIT    3
`define CK_CTRL_VAL_BIT     2
`define CK_AUTO_EN_BIT      7
`define CK_AUTO_DONE_BIT    6
`define CK_CTRL_RESET       8'h00
`define CK_AUTO_RESET       8'h40
`define CK_COUNT_RESET      8'h00

// ----------------------------------------------------------------------------
// Polynomials, init values, scan geometry
// ----------------------------------------------------------------------------
`define CK_POLY16           16'h1021
`define CK_POLY32_REFL      32'hedb88320
`define CK_INIT_ZERO        32'h0000_0000
`define CK_INIT_ONES        32'hffff_ffff
`define CK_SECTOR_SHIFT     10
`define CK_FULL_SPACE       17'h1_0000

`endif

// file: verilog/checksum_pkg.sv
`default_nettype none

package checksum_pkg;

	typedef enum logic [1:0] {
		S_IDLE,
		S_FETCH,
		S_WAIT
	} scan_state_e;

	typedef enum logic [2:0] {
		H_IDLE,
		H_ACC,
		H_STEP,
		H_HOLD,
		H_READ,
		H_RDWAIT
	} host_state_e;

	typedef logic [7:0] byte_t;

endpackage

`default_nettype wire

// file: verilog/sfr_link_if.sv
`default_nettype none

interface sfr_link_if;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;
	logic       cpu_hold;
	logic [1:0] code_bank_select;

	modport device_mp (
		input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd, code_bank_select,
		output sfr_rdata, cpu_hold
	);

	modport cpu_mp (
		output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, code_bank_select,
		input  sfr_rdata, cpu_hold
	);
endinterface

`default_nettype wire

// file: verilog/checksum_cpu_end.sv
`include "checksum_defs.svh"
`default_nettype none

module checksum_cpu_end (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	sfr_link_if.cpu_mp       link,
	input  wire logic        acc_req_i,
	input  wire logic        acc_wr_i,
	input  wire logic [7:0]  acc_addr_i,
	input  wire logic [7:0]  acc_wdata_i,
	output logic             acc_ready_o,
	output logic             acc_done_o,
	output logic [7:0]       acc_rdata_o,
	input  wire logic        job_req_i,
	input  wire logic        job_width16_i,
	input  wire logic        job_initval_i,
	input  wire logic [5:0]  job_start_i,
	input  wire logic [5:0]  job_count_i,
	input  wire logic [1:0]  job_bank_i,
	output logic             job_done_o,
	output logic [31:0]      job_result_o
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	checksum_pkg::host_state_e state_r;
	logic [2:0]                step_r;
	logic [1:0]                rbyte_r;
	logic                      w16_r, val_r;
	logic [5:0]                start_r, count_r;
	logic [1:0]                bank_r;
	logic [7:0]                addr_r, wdata_r;
	logic                      wr_r, rd_r;
	logic                      acc_done_r, job_done_r;
	logic [7:0]                acc_rdata_r;
	logic [31:0]               result_r;

	// ------------------------------------------------------------------------
	// Scan job steps
	// ------------------------------------------------------------------------
	wire [7:0] ctrl_base = {3'b000, w16_r, 1'b0, val_r, 2'b00};
	logic [7:0] step_addr, step_data;
	always_comb begin
		step_addr = `CK_ADDR_CONTROL;
		step_data = ctrl_base;
		unique case (step_r)
			3'd0: step_data = ctrl_base | 8'h08;
			3'd1: begin
				step_addr = `CK_ADDR_AUTO;
				step_data = {2'b00, start_r};
			end
			3'd2: begin
				step_addr = `CK_ADDR_AUTO;
				step_data = {2'b10, start_r};
			end
			3'd3: begin
				step_addr = `CK_ADDR_COUNT;
				step_data = {2'b00, count_r};
			end
			3'd4: step_data = ctrl_base;
			3'd5: begin
				step_addr = `CK_ADDR_AUTO;
				step_data = {2'b00, start_r};
			end
			default: step_data = ctrl_base;
		endcase
	end

	wire [1:0] last_byte = w16_r ? 2'd1 : 2'd3;

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r     <= checksum_pkg::H_IDLE;
			step_r      <= 3'd0;
			rbyte_r     <= 2'd0;
			w16_r       <= 1'b0;
			val_r       <= 1'b0;
			start_r     <= 6'h00;
			count_r     <= 6'h00;
			bank_r      <= 2'b00;
			addr_r      <= 8'h00;
			wdata_r     <= 8'h00;
			wr_r        <= 1'b0;
			rd_r        <= 1'b0;
			acc_done_r  <= 1'b0;
			job_done_r  <= 1'b0;
			acc_rdata_r <= 8'h00;
			result_r    <= 32'h0000_0000;
		end else begin
			wr_r       <= 1'b0;
			rd_r       <= 1'b0;
			acc_done_r <= 1'b0;
			job_done_r <= 1'b0;
			unique case (state_r)
				checksum_pkg::H_IDLE: begin
					if (job_req_i) begin
						// Bank only changes between jobs, never under a scan
						w16_r   <= job_width16_i;
						val_r   <= job_initval_i;
						start_r <= job_start_i;
						count_r <= job_count_i;
						bank_r  <= job_bank_i;
						step_r  <= 3'd0;
						state_r <= checksum_pkg::H_STEP;
					end else if (acc_req_i) begin
						addr_r  <= acc_addr_i;
						wdata_r <= acc_wdata_i;
						wr_r    <= acc_wr_i;
						rd_r    <= !acc_wr_i;
						state_r <= checksum_pkg::H_ACC;
					end
				end
				checksum_pkg::H_ACC: begin
					// Read data lands a cycle after the strobe, so wait it out
					if (!rd_r) begin
						acc_done_r  <= 1'b1;
						acc_rdata_r <= link.sfr_rdata;
						state_r     <= checksum_pkg::H_IDLE;
					end
				end
				checksum_pkg::H_STEP: begin
					addr_r  <= step_addr;
					wdata_r <= step_data;
					wr_r    <= 1'b1;
					step_r  <= step_r + 3'd1;
					if (step_r == 3'd4) begin
						state_r <= checksum_pkg::H_HOLD;
					end else if (step_r == 3'd5) begin
						rbyte_r <= 2'd0;
						state_r <= checksum_pkg::H_READ;
					end
				end
				checksum_pkg::H_HOLD: begin
					if (!link.cpu_hold) begin
						state_r <= checksum_pkg::H_STEP;
					end
				end
				checksum_pkg::H_READ: begin
					addr_r  <= `CK_ADDR_RESULT;
					rd_r    <= 1'b1;
					state_r <= checksum_pkg::H_RDWAIT;
				end
				checksum_pkg::H_RDWAIT: begin
					if (!rd_r) begin
						result_r[8*rbyte_r +: 8] <= link.sfr_rdata;
						rbyte_r <= rbyte_r + 2'd1;
						if (rbyte_r == last_byte) begin
							job_done_r <= 1'b1;
							state_r    <= checksum_pkg::H_IDLE;
						end else begin
							state_r <= checksum_pkg::H_READ;
						end
					end
				end
				default: state_r <= checksum_pkg::H_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign link.sfr_addr         = addr_r;
	assign link.sfr_wdata        = wdata_r;
	assign link.sfr_wr           = wr_r;
	assign link.sfr_rd           = rd_r;
	assign link.code_bank_select = bank_r;
	assign acc_ready_o           = (state_r == checksum_pkg::H_IDLE) && !job_req_i;
	assign acc_done_o            = acc_done_r;
	assign acc_rdata_o           = acc_rdata_r;
	assign job_done_o            = job_done_r;
	assign job_result_o          = result_r;

endmodule // checksum_cpu_end

`default_nettype wire

// file: testbench/checksum_asserts.sv
`include "checksum_defs.svh"
`default_nettype none

module checksum_asserts (
	input wire logic       ref_clk_i,
	input wire logic       rst_b_i,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       cpu_hold,
	input wire logic [1:0] code_bank_select
);
	// ------------------------------------------------------------
	// Shadow of the scan setup, rebuilt from bus traffic
	// ------------------------------------------------------------
	logic       auto_en_r;
	logic [5:0] count_r;
	wire        ctrl_wr = sfr_wr && (sfr_addr == `CK_ADDR_CONTROL);
	wire        ctrl_rd = sfr_rd && (sfr_addr == `CK_ADDR_CONTROL);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			auto_en_r <= 1'b0;
			count_r   <= 6'h00;
		end else if (sfr_wr && sfr_addr == `CK_ADDR_AUTO) begin
			auto_en_r <= sfr_wdata[`CK_AUTO_EN_BIT];
		end else if (sfr_wr && sfr_addr == `CK_ADDR_COUNT) begin
			count_r <= sfr_wdata[5:0];
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	ctrl_pad_a: assert property (ctrl_rd |=> sfr_rdata[7:5] == 3'b000)
		else $error("control pad bits not zero");
	init_bit_a: assert property (ctrl_rd |=> !sfr_rdata[3])
		else $error("init strobe reads back set");
	hold_quiet_a: assert property (cpu_hold && !ctrl_wr |-> !sfr_wr && !sfr_rd)
		else $error("bus access while held");
	done_bit_a: assert property (sfr_rd && sfr_addr == `CK_ADDR_AUTO |=> sfr_rdata[6])
		else $error("done bit low outside scan");
	scan_trig_a: assert property (ctrl_wr && auto_en_r |-> cpu_hold)
		else $error("control write did not start scan");
	// A sector holds far more than eight fetches, so hold must persist
	scan_run_a: assert property (ctrl_wr && auto_en_r && count_r != 6'h00 |=> cpu_hold[*8])
		else $error("scan ended too early");
	read_clear_a: assert property (sfr_rd && sfr_addr == `CK_ADDR_RESULT |-> !auto_en_r)
		else $error("result read with auto enable set");
	count_order_a: assert property (sfr_wr && sfr_addr == `CK_ADDR_COUNT |-> auto_en_r)
		else $error("count written before enable");
	bank_still_a: assert property (cpu_hold |=> $stable(code_bank_select))
		else $error("bank changed during scan");

	cover property (ctrl_wr && auto_en_r);
	cover property (sfr_rd && sfr_addr == `CK_ADDR_RESULT);
	cover property ($fell(cpu_hold));
endmodule // checksum_asserts

`default_nettype wire

// file: testbench/tb_top.sv
`include "checksum_defs.svh"
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        ref_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        flash_rd_o, scan_busy_o, acc_ready_o, acc_done_o, job_done_o;
	logic [17:0] flash_addr_o, exp_addr = 18'h0, faddr = 18'h0;
	logic [7:0]  flash_data_i = 8'h00, acc_addr_i = 8'h00, acc_wdata_i = 8'h00, acc_rdata_o;
	logic        flash_valid_i = 1'b0, acc_req_i = 1'b0, acc_wr_i = 1'b0, pend = 1'b0;
	logic        job_req_i = 1'b0, job_width16_i = 1'b0, job_initval_i = 1'b0, w, v;
	logic [5:0]  job_start_i = 6'h00, job_count_i = 6'h00;
	logic [1:0]  job_bank_i = 2'h0, dly = 2'h0;
	logic [31:0] crc_result_o, job_result_o, exp;
	logic [7:0]  seed = 8'h17, fseed = 8'h17, q;
	logic [7:0]  ra [5] = '{8'h92, 8'h96, 8'h97, 8'h55, 8'h91};
	logic [7:0]  rv [5] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
	int          fails = 0, cmp_count = 0, t, k, n;

	always #2 ref_clk_i = ~ref_clk_i;

	sfr_link_if link ();
	checksum_unit i_checksum_unit (.ref_clk_i, .rst_b_i, .link(link), .flash_rd_o,
		.flash_addr_o, .flash_data_i, .flash_valid_i, .crc_result_o, .scan_busy_o);
	checksum_cpu_end i_checksum_cpu_end (.ref_clk_i, .rst_b_i, .link(link), .acc_req_i,
		.acc_wr_i, .acc_addr_i, .acc_wdata_i, .acc_ready_o, .acc_done_o, .acc_rdata_o,
		.job_req_i, .job_width16_i, .job_initval_i, .job_start_i, .job_count_i,
		.job_bank_i, .job_done_o, .job_result_o);
	checksum_asserts i_checksum_asserts (.ref_clk_i, .rst_b_i, .sfr_addr(link.sfr_addr),
		.sfr_wdata(link.sfr_wdata), .sfr_wr(link.sfr_wr), .sfr_rd(link.sfr_rd),
		.sfr_rdata(link.sfr_rdata), .cpu_hold(link.cpu_hold),
		.code_bank_select(link.code_bank_select));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Sector and bank bits mixed in, so a wrong base address shows up
	function automatic logic [7:0] fbyte(input logic [17:0] a);
		return a[7:0] ^ {a[15:10], a[17:16]};
	endfunction

	function automatic logic [31:0] step(input logic w16, input logic [31:0] c,
		input logic [7:0] b);
		int i;
		if (w16) begin
			c[15:8] = c[15:8] ^ b;
			for (i = 0; i < 8; i++) c[15:0] = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0);
		end else begin
			c[7:0] = c[7:0] ^ b;
			for (i = 0; i < 8; i++) c = (c >> 1) ^ (c[0] ? 32'hedb88320 : 32'h0);
		end
		return c;
	endfunction

	function automatic logic [7:0] lane(input logic [31:0] c, input logic w16,
		input logic [1:0] p);
		return w16 ? (p[0] ? c[15:8] : c[7:0]) : c[8*p +: 8];
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic end_of_test;
		if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tmo(input logic ok);
		if (!ok) begin
			fails++;
			end_of_test();
		end
	endtask

	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int m;
		@(posedge ref_clk_i);
		acc_req_i   <= 1'b1;
		acc_wr_i    <= wr;
		acc_addr_i  <= a;
		acc_wdata_i <= d;
		m = 0;
		do begin @(negedge ref_clk_i); m++; end while (acc_ready_o !== 1'b1 && m < 100);
		tmo(m < 100);
		@(posedge ref_clk_i);
		acc_req_i <= 1'b0;
		m = 0;
		do begin @(negedge ref_clk_i); m++; end while (acc_done_o !== 1'b1 && m < 8);
		tmo(m < 8);
		r = acc_rdata_o;
	endtask

	task automatic job(input logic w16, input logic iv, input logic [5:0] s,
		input logic [5:0] c, input logic [1:0] b);
		logic [31:0] e;
		logic [15:0] a16;
		int          m;
		e = iv ? 32'hffffffff : 32'h0;
		for (m = 0; m < c * 1024; m++) begin
			a16 = {s, 10'h000} + 16'(m);
			e = step(w16, e, fbyte({b, a16}));
		end
		exp_addr = {b, s, 10'h000};
		@(posedge ref_clk_i);
		{job_width16_i, job_initval_i, job_start_i, job_count_i, job_bank_i} <= {w16, iv, s, c, b};
		job_req_i <= 1'b1;
		@(posedge ref_clk_i);
		job_req_i <= 1'b0;
		m = 0;
		do begin @(negedge ref_clk_i); m++; end while (job_done_o !== 1'b1 && m < 20000);
		tmo(m < 20000);
		check(w16 ? {16'h0, job_result_o[15:0]} : job_result_o, w16 ? {16'h0, e[15:0]} : e);
		check({31'h0, scan_busy_o}, 32'h0);
	endtask

	// ------------------------------------------------------------
	// Flash: answers at random after 0 to 3 idle cycles
	// ------------------------------------------------------------
	always @(posedge ref_clk_i) begin
		fseed = lfsr(fseed);
		flash_valid_i <= 1'b0;
		flash_data_i  <= fseed;
		if (pend && dly == 2'd0) begin
			flash_valid_i <= 1'b1;
			flash_data_i  <= fbyte(faddr);
			pend          <= 1'b0;
		end else if (pend) begin
			dly <= dly - 2'd1;
		end
		if ($sampled(flash_rd_o)) begin
			check({14'h0, $sampled(flash_addr_o)}, {14'h0, exp_addr});
			exp_addr[15:0] = exp_addr[15:0] + 16'h0001;
			faddr <= $sampled(flash_addr_o);
			pend  <= 1'b1;
			dly   <= fseed[1:0];
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		for (t = 0; t < 5; t++) begin
			acc(1'b0, ra[t], 8'h00, q);
			check({24'h0, q}, {24'h0, rv[t]});
		end
		for (t = 0; t < 6; t++) begin
			seed = lfsr(seed);
			w = seed[0];
			v = seed[1];
			n = 1 + seed[3:2];
			exp = v ? 32'hffffffff : 32'h0;
			acc(1'b1, 8'h92, {seed[7:5], w, 1'b1, v, 2'b00}, q);
			for (k = 0; k < n; k++) begin
				seed = lfsr(seed);
				acc(1'b1, 8'h93, seed, q);
				exp = step(w, exp, seed);
			end
			check(crc_result_o, exp);
			acc(1'b0, 8'h92, 8'h00, q);
			check({24'h0, q}, {27'h0, w, 1'b0, v, 2'b00});
			acc(1'b1, 8'h92, {3'b111, w, 1'b0, v, 2'b00}, q);
			for (k = 0; k < 5; k++) begin
				acc(1'b0, 8'h91, 8'h00, q);
				check({24'h0, q}, {24'h0, lane(exp, w, 2'(k))});
			end
			check(crc_result_o, exp);
			seed = lfsr(seed);
			acc(1'b1, 8'h91, seed, q);
			exp[15:8] = seed;
			acc(1'b0, 8'h91, 8'h00, q);
			check({24'h0, q}, {24'h0, lane(exp, w, 2'b10)});
			check(crc_result_o, exp);
		end
		job(1'b0, 1'b1, 6'd0, 6'd1, 2'd0);
		job(1'b1, 1'b0, 6'd63, 6'd2, 2'd3);
		job(1'b0, 1'b0, 6'd5, 6'd0, 2'd1);
		for (t = 0; t < 3; t++) begin
			seed = lfsr(seed);
			job(seed[0], seed[1], seed[7:2], 6'd1, seed[3:2]);
		end
		end_of_test();
	end
endmodule // tb_top

`default_nettype wire
